// >>> pkg/trig_pkg.sv
// trigger qualification package: register map, field positions, reset values
// assumes a plain register port and one 100 MHz clock
package trig_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 3;
  // register indices (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] REG_TRIGGER_DEFINITION = 3'h0;
  localparam logic [ADDR_W-1:0] REG_DATA_COMPARE_VALUE = 3'h1;
  localparam logic [ADDR_W-1:0] REG_ADDRESS_LOW_LIMIT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_ADDRESS_HIGH_LIMIT = 3'h3;
  localparam logic [ADDR_W-1:0] REG_PC_COMPARE_VALUE = 3'h4;
  localparam logic [ADDR_W-1:0] REG_PC_COMPARE_MASK = 3'h5;
  localparam logic [ADDR_W-1:0] REG_TRIGGER_STATUS = 3'h6;
  // field positions inside one 16-bit condition set
  localparam int HALF_W = 16;
  localparam int F_LONGWORD = 12;
  localparam int F_LOWER_WORD = 11;
  localparam int F_UPPER_WORD = 10;
  localparam int F_BYTE0 = 9;
  localparam int F_BYTE1 = 8;
  localparam int F_BYTE2 = 7;
  localparam int F_BYTE3 = 6;
  localparam int F_DATA_INVERT = 5;
  localparam int F_ADDR_OUTSIDE = 4;
  localparam int F_ADDR_RANGE = 3;
  localparam int F_ADDR_LOW = 2;
  localparam int F_PC_ENABLE = 1;
  localparam int F_PC_INVERT = 0;
  localparam logic [DATA_W-1:0] TRIGGER_DEFINITION_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;
endpackage

// >>> src/trigger_enables.sv
// breakpoint trigger qualification: two condition sets watching data, address and pc
// assumes bus and pc observations are synchronous to clock; one register port
// Summary of operation
// R01: data enables arm lane matches; none, data cannot fire
// R02: longword enable compares all 32 bits
// R03: word enables compare low or high half
// R04: byte enables compare one byte lane each
// R05: data invert flips every data comparator
// R06: address enables arm modes; none disables address
// R07: outside enable fires beyond low/high limits
// R08: range enable fires within inclusive limits
// R09: low enable fires on low limit match
// R10: pc breakpoint counts only when enabled
// R11: pc invert selects outside masked region
// R12: upper and lower sets evaluated independently
`timescale 1ns/1ps
`default_nettype none
module trigger_enables
  import trig_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic bus_valid,
  input wire logic [DATA_W-1:0] bus_data,
  input wire logic [DATA_W-1:0] bus_address,
  input wire logic pc_valid,
  input wire logic [DATA_W-1:0] pc_value,
  output logic trigger_upper,
  output logic trigger_lower
);

  typedef struct packed {
    logic [DATA_W-1:0] trigger_definition;
    logic [DATA_W-1:0] data_compare_value;
    logic [DATA_W-1:0] address_low_limit;
    logic [DATA_W-1:0] address_high_limit;
    logic [DATA_W-1:0] pc_compare_value;
    logic [DATA_W-1:0] pc_compare_mask;
    logic [DATA_W-1:0] rdata;
    logic trig_upper;
    logic trig_lower;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  // one condition set: returns 1 when at least one condition is armed and all armed ones hold
  function automatic logic set_hit(input logic [HALF_W-1:0] f, input logic [DATA_W-1:0] dv,
                                   input logic [DATA_W-1:0] d, input logic bv,
                                   input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] lo,
                                   input logic [DATA_W-1:0] hi, input logic pv,
                                   input logic [DATA_W-1:0] pc, input logic [DATA_W-1:0] pcv,
                                   input logic [DATA_W-1:0] pcm);
    logic [DATA_W-1:0] lane;
    logic dmatch;
    logic armed_d;
    logic armed_a;
    logic amatch;
    logic in_range;
    logic pin;
    logic ok;
    lane = '0;
    // R02 whole bus lane mask
    if (f[F_LONGWORD]) lane = lane | 32'hffff_ffff;
    // R03 half-word lane masks
    if (f[F_LOWER_WORD]) lane = lane | 32'h0000_ffff;
    if (f[F_UPPER_WORD]) lane = lane | 32'hffff_0000;
    // R04 byte lane masks
    if (f[F_BYTE0]) lane = lane | 32'h0000_00ff;
    if (f[F_BYTE1]) lane = lane | 32'h0000_ff00;
    if (f[F_BYTE2]) lane = lane | 32'h00ff_0000;
    if (f[F_BYTE3]) lane = lane | 32'hff00_0000;
    // R01 no enables, no data arming
    armed_d = |f[F_LONGWORD:F_BYTE3];
    dmatch = ((d & lane) == (dv & lane));
    // R05 invert data comparator sense
    if (f[F_DATA_INVERT]) dmatch = !dmatch;
    in_range = (a >= lo) && (a <= hi);
    amatch = 1'b0;
    // R07 outside the limits
    if (f[F_ADDR_OUTSIDE] && !in_range) amatch = 1'b1;
    // R08 inclusive range
    if (f[F_ADDR_RANGE] && in_range) amatch = 1'b1;
    // R09 low limit equality
    if (f[F_ADDR_LOW] && (a == lo)) amatch = 1'b1;
    // R06 address armed by any enable
    armed_a = |f[F_ADDR_OUTSIDE:F_ADDR_LOW];
    // R11 masked region, optional invert
    pin = ((pc & ~pcm) == (pcv & ~pcm)) ^ f[F_PC_INVERT];
    ok = armed_d | armed_a | f[F_PC_ENABLE];
    if (armed_d && !(bv && dmatch)) ok = 1'b0;
    if (armed_a && !(bv && amatch)) ok = 1'b0;
    // R10 pc used only when enabled
    if (f[F_PC_ENABLE] && !(pv && pin)) ok = 1'b0;
    return ok;
  endfunction

  // register writes, reads and trigger evaluation
  always_comb begin
    st_nxt = st_r;
    if (reg_write) begin
      case (reg_addr)
        REG_TRIGGER_DEFINITION: st_nxt.trigger_definition = reg_wdata;
        REG_DATA_COMPARE_VALUE: st_nxt.data_compare_value = reg_wdata;
        REG_ADDRESS_LOW_LIMIT: st_nxt.address_low_limit = reg_wdata;
        REG_ADDRESS_HIGH_LIMIT: st_nxt.address_high_limit = reg_wdata;
        REG_PC_COMPARE_VALUE: st_nxt.pc_compare_value = reg_wdata;
        REG_PC_COMPARE_MASK: st_nxt.pc_compare_mask = reg_wdata;
        default: st_nxt.rdata = st_r.rdata; // unmapped writes ignored
      endcase
    end
    // read data only stands in the cycle after the strobe
    st_nxt.rdata = READ_UNMAPPED;
    if (reg_read) begin
      case (reg_addr)
        REG_TRIGGER_DEFINITION: st_nxt.rdata = st_r.trigger_definition;
        REG_DATA_COMPARE_VALUE: st_nxt.rdata = st_r.data_compare_value;
        REG_ADDRESS_LOW_LIMIT: st_nxt.rdata = st_r.address_low_limit;
        REG_ADDRESS_HIGH_LIMIT: st_nxt.rdata = st_r.address_high_limit;
        REG_PC_COMPARE_VALUE: st_nxt.rdata = st_r.pc_compare_value;
        REG_PC_COMPARE_MASK: st_nxt.rdata = st_r.pc_compare_mask;
        REG_TRIGGER_STATUS: st_nxt.rdata = {30'h0, st_r.trig_upper, st_r.trig_lower};
        default: st_nxt.rdata = READ_UNMAPPED;
      endcase
    end
    // R12 two independent sets, same observations
    st_nxt.trig_upper = set_hit(st_r.trigger_definition[DATA_W-1:HALF_W],
                                st_r.data_compare_value, bus_data, bus_valid, bus_address,
                                st_r.address_low_limit, st_r.address_high_limit, pc_valid,
                                pc_value, st_r.pc_compare_value, st_r.pc_compare_mask);
    st_nxt.trig_lower = set_hit(st_r.trigger_definition[HALF_W-1:0],
                                st_r.data_compare_value, bus_data, bus_valid, bus_address,
                                st_r.address_low_limit, st_r.address_high_limit, pc_valid,
                                pc_value, st_r.pc_compare_value, st_r.pc_compare_mask);
  end

  // state register; reset leaves all sets disarmed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{TRIGGER_DEFINITION_RESET, WORD_RESET, WORD_RESET, WORD_RESET,
                WORD_RESET, WORD_RESET, READ_UNMAPPED, 1'b0, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign trigger_upper = st_r.trig_upper;
  assign trigger_lower = st_r.trig_lower;

  // R01 no data enables, data cannot block or fire alone
  property p_no_enables_no_fire;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0000) |=> !trigger_lower;
  endproperty
  a_no_enables_no_fire: assert property (p_no_enables_no_fire) // R01
    else $error("lower fired disarmed");

  // R02 longword match fires lower set
  property p_longword;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h1000 && bus_valid &&
     bus_data == st_r.data_compare_value && !reg_write) |=> trigger_lower;
  endproperty
  a_longword: assert property (p_longword) else $error("longword match missed"); // R02

  // R03 lower word mismatch blocks the lower set
  property p_lower_word;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0800 && bus_valid &&
     bus_data[15:0] != st_r.data_compare_value[15:0] && !reg_write) |=> !trigger_lower;
  endproperty
  a_lower_word: assert property (p_lower_word) else $error("lower word mismatch fired"); // R03

  // R04 byte3 lane match fires
  property p_byte3;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0040 && bus_valid &&
     bus_data[31:24] == st_r.data_compare_value[31:24] && !reg_write) |=> trigger_lower;
  endproperty
  a_byte3: assert property (p_byte3) else $error("byte3 match missed"); // R04

  // R05 inverted longword fires on difference
  property p_invert;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h1020 && bus_valid &&
     bus_data != st_r.data_compare_value && !reg_write) |=> trigger_lower;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted compare missed"); // R05

  // R08 inclusive range fires at the high limit
  property p_range;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0008 && bus_valid &&
     bus_address == st_r.address_high_limit &&
     st_r.address_low_limit <= st_r.address_high_limit && !reg_write) |=> trigger_lower;
  endproperty
  a_range: assert property (p_range) else $error("range end missed"); // R08

  // R09 low match requires equality
  property p_low;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0004 &&
     bus_address != st_r.address_low_limit && !reg_write) |=> !trigger_lower;
  endproperty
  a_low: assert property (p_low) else $error("low match false fire"); // R09

  // R11 pc outside region with invert
  property p_pc_invert;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0003 && pc_valid &&
     (pc_value & ~st_r.pc_compare_mask) != (st_r.pc_compare_value & ~st_r.pc_compare_mask)
     && !reg_write) |=> trigger_lower;
  endproperty
  a_pc_invert: assert property (p_pc_invert) else $error("pc outside missed"); // R11

  // R12 upper set alone never moves the lower trigger
  property p_independent;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0000 &&
     st_r.trigger_definition[DATA_W-1:HALF_W] != 16'h0000) |=> !trigger_lower;
  endproperty
  a_independent: assert property (p_independent) else $error("sets not independent"); // R12

  // R01 empty upper set stays quiet
  property p_no_enables_upper;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[DATA_W-1:HALF_W] == 16'h0000) |=> !trigger_upper;
  endproperty
  a_no_enables_upper: assert property (p_no_enables_upper) else $error("upper fired"); // R01

  // R02 longword difference blocks the lower set
  property p_longword_miss;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h1000 &&
     bus_data != st_r.data_compare_value) |=> !trigger_lower;
  endproperty
  a_longword_miss: assert property (p_longword_miss) else $error("longword miss fired"); // R02

  // R03 upper word ignores the lower half
  property p_upper_word;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0400 && bus_valid &&
     bus_data[31:16] == st_r.data_compare_value[31:16]) |=> trigger_lower;
  endproperty
  a_upper_word: assert property (p_upper_word) else $error("upper word match missed"); // R03

  // R04 byte0 lane match fires
  property p_byte0;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0200 && bus_valid &&
     bus_data[7:0] == st_r.data_compare_value[7:0]) |=> trigger_lower;
  endproperty
  a_byte0: assert property (p_byte0) else $error("byte0 match missed"); // R04

  // R05 inverted upper set quiet on an equal word
  property p_invert_equal;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[DATA_W-1:HALF_W] == 16'h1020 &&
     bus_data == st_r.data_compare_value) |=> !trigger_upper;
  endproperty
  a_invert_equal: assert property (p_invert_equal) else $error("inverted equal fired"); // R05

  // R06 armed address modes need a bus access
  property p_address_needs_bus;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W+F_ADDR_OUTSIDE:HALF_W+F_ADDR_LOW] != 3'h0 &&
     !bus_valid) |=> !trigger_upper;
  endproperty
  a_address_needs_bus: assert property (p_address_needs_bus) // R06
    else $error("address fired idle");

  // R07 below the low limit counts as outside
  property p_outside_below;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[DATA_W-1:HALF_W] == 16'h0010 && bus_valid &&
     bus_address < st_r.address_low_limit) |=> trigger_upper;
  endproperty
  a_outside_below: assert property (p_outside_below) else $error("outside miss"); // R07

  // R10 pc invert alone never fires
  property p_pc_off;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[DATA_W-1:HALF_W] == 16'h0001) |=> !trigger_upper;
  endproperty
  a_pc_off: assert property (p_pc_off) else $error("disabled pc fired"); // R10

  // R11 pc inside the masked region
  property p_pc_inside;
    @(posedge clock) disable iff (rst)
    (st_r.trigger_definition[HALF_W-1:0] == 16'h0002 && pc_valid &&
     (pc_value & ~st_r.pc_compare_mask) == (st_r.pc_compare_value & ~st_r.pc_compare_mask))
    |=> trigger_lower;
  endproperty
  a_pc_inside: assert property (p_pc_inside) else $error("pc inside missed"); // R11

  // register read steps: strobe, then data for exactly one cycle
  sequence s_definition_read;
    reg_read && reg_addr == REG_TRIGGER_DEFINITION;
  endsequence
  sequence s_status_read;
    reg_read && reg_addr == REG_TRIGGER_STATUS;
  endsequence
  property p_definition_read;
    @(posedge clock) disable iff (rst)
    s_definition_read |=> reg_rdata == $past(st_r.trigger_definition);
  endproperty
  a_definition_read: assert property (p_definition_read) else $error("definition read wrong");

  // idle port returns zero, so stale data cannot be mistaken for a read
  property p_rdata_one_cycle;
    @(posedge clock) disable iff (rst)
    !reg_read |=> reg_rdata == READ_UNMAPPED;
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data lingered");

  // R12 status shows both sets side by side
  property p_status_read;
    @(posedge clock) disable iff (rst)
    s_status_read |=> reg_rdata[1] == $past(trigger_upper) &&
                      reg_rdata[0] == $past(trigger_lower);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bits wrong"); // R12

endmodule
`default_nettype wire

// >>> test/core_bus_model.sv
// core-side model: local bus and program counter observations for the trigger block
// assumes the bench calls put once per sampled cycle on the shared clock
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
  import trig_pkg::*;
(
  input wire logic clock,
  output logic bus_valid,
  output logic [DATA_W-1:0] bus_data,
  output logic [DATA_W-1:0] bus_address,
  output logic pc_valid,
  output logic [DATA_W-1:0] pc_value
);
  // quiet lines at time zero
  initial begin
    bus_valid = 1'b0;
    bus_data = 32'h0;
    bus_address = 32'h0;
    pc_valid = 1'b0;
    pc_value = 32'h0;
  end
  // idle lines show inverted old values, so a stale match cannot pass
  task automatic put(input logic bv, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] a,
                     input logic pv, input logic [DATA_W-1:0] pc);
    @(posedge clock);
    bus_valid <= bv;
    bus_data <= bv ? d : ~bus_data;
    bus_address <= bv ? a : ~bus_address;
    pc_valid <= pv;
    pc_value <= pv ? pc : ~pc_value;
  endtask
endmodule
`default_nettype wire

// >>> test/breakpoint_trigger_enables_tb.sv
// self-checking bench for the trigger qualification block
// assumes the core model drives observations; registers reached over the plain port
`timescale 1ns/1ps
`default_nettype none
module breakpoint_trigger_enables_tb;
  import trig_pkg::*;
  logic clock, rst, reg_write, reg_read, bus_valid, pc_valid, trigger_upper, trigger_lower;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, bus_data, bus_address, pc_value;
  logic [DATA_W-1:0] lane_mask [7];
  int failures = 0;
  int num_checks = 0;
  trigger_enables u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
    .bus_data(bus_data), .bus_address(bus_address), .pc_valid(pc_valid), .pc_value(pc_value),
    .trigger_upper(trigger_upper), .trigger_lower(trigger_lower));
  core_bus_model u_core (.clock(clock), .bus_valid(bus_valid), .bus_data(bus_data),
    .bus_address(bus_address), .pc_valid(pc_valid), .pc_value(pc_value));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // single exit point for verdict
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask
  // one-cycle strobes, launched right after an edge
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk_word("reg_rdata", e, reg_rdata);
  endtask
  // one observed cycle, triggers judged one cycle later
  task automatic obs(input logic bv, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] a,
                     input logic pv, input logic [DATA_W-1:0] pc, input logic eu, input logic el);
    u_core.put(bv, d, a, pv, pc);
    @(posedge clock);
    #1 chk_bit("trigger_upper", eu, trigger_upper);
    chk_bit("trigger_lower", el, trigger_lower);
  endtask
  // reset values, read-back, read-only and unmapped places
  task automatic t_regs;
    for (int i = 0; i < 8; i++) reg_rd(i[2:0], 32'h0);
    for (int i = 0; i < 6; i++) reg_wr(i[2:0], 32'ha5a5_a5a0 ^ i);
    reg_wr(3'h6, 32'hffff_ffff);
    reg_wr(3'h7, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) reg_rd(i[2:0], 32'ha5a5_a5a0 ^ i);
    reg_rd(3'h6, 32'h0);
    reg_rd(3'h7, 32'h0);
  endtask
  // each lane alone; upper set is the inverted twin of the lower set
  task automatic t_data;
    logic [15:0] en;
    logic [DATA_W-1:0] m;
    reg_wr(3'h1, 32'h1122_3344);
    for (int k = 0; k < 7; k++) begin
      en = 16'h1 << (F_LONGWORD - k);
      m = lane_mask[k];
      reg_wr(3'h0, {en | 16'h0020, en});
      // lane equal, outside differs; then lowest lane bit differs
      obs(1'b1, 32'h1122_3344 ^ ~m, 32'h0, 1'b0, 32'h0, 1'b0, 1'b1);
      obs(1'b1, 32'h1122_3344 ^ (m & ~(m - 32'h1)), 32'h0, 1'b0, 32'h0, 1'b1, 1'b0);
    end
    obs(1'b0, 32'h1122_3344, 32'h0, 1'b0, 32'h0, 1'b0, 1'b0);
    reg_wr(3'h0, 32'h0);
    obs(1'b1, 32'h1122_3344, 32'h0, 1'b0, 32'h0, 1'b0, 1'b0);
  endtask
  // range bounds inside and outside, then low match with an empty upper set
  task automatic t_addr;
    logic [DATA_W-1:0] av [4] = '{32'h0ff, 32'h100, 32'h1ff, 32'h200};
    logic el [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    reg_wr(3'h2, 32'h100);
    reg_wr(3'h3, 32'h1ff);
    reg_wr(3'h0, 32'h0010_0008);
    for (int i = 0; i < 4; i++) obs(1'b1, 32'h0, av[i], 1'b0, 32'h0, ~el[i], el[i]);
    reg_wr(3'h0, 32'h0000_0004);
    obs(1'b1, 32'h0, 32'h100, 1'b0, 32'h0, 1'b0, 1'b1);
    obs(1'b1, 32'h0, 32'h101, 1'b0, 32'h0, 1'b0, 1'b0);
  endtask
  // masked pc region, inverted twin, then invert without enable
  task automatic t_pc;
    reg_wr(3'h4, 32'h4000);
    reg_wr(3'h5, 32'h00ff);
    reg_wr(3'h0, 32'h0003_0002);
    obs(1'b0, 32'h0, 32'h0, 1'b1, 32'h4080, 1'b0, 1'b1);
    reg_rd(3'h6, 32'h0000_0001);
    obs(1'b0, 32'h0, 32'h0, 1'b1, 32'h5000, 1'b1, 1'b0);
    reg_rd(3'h6, 32'h0000_0002);
    obs(1'b0, 32'h0, 32'h0, 1'b0, 32'h4080, 1'b0, 1'b0);
    reg_wr(3'h0, 32'h0001_0000);
    obs(1'b0, 32'h0, 32'h0, 1'b1, 32'h5000, 1'b0, 1'b0);
  endtask
  // mid-run reset: a standing trigger drops, registers clear, the set is disarmed
  task automatic t_reset;
    reg_wr(3'h0, 32'h0000_1000);
    reg_wr(3'h1, 32'h1122_3344);
    obs(1'b1, 32'h1122_3344, 32'h0, 1'b0, 32'h0, 1'b0, 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    #1 chk_bit("trigger_lower", 1'b0, trigger_lower);
    chk_bit("trigger_upper", 1'b0, trigger_upper);
    @(posedge clock);
    rst <= 1'b0;
    reg_rd(3'h0, 32'h0);
    reg_rd(3'h1, 32'h0);
    reg_rd(3'h4, 32'h0);
    obs(1'b1, 32'h1122_3344, 32'h0, 1'b0, 32'h0, 1'b0, 1'b0);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    finish_test;
  end
  initial begin
    lane_mask = '{32'hffff_ffff, 32'h0000_ffff, 32'hffff_0000, 32'h0000_00ff,
                  32'h0000_ff00, 32'h00ff_0000, 32'hff00_0000};
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_data;
    t_addr;
    t_pc;
    t_reset;
    finish_test;
  end
endmodule
`default_nettype wire
